/* File: rtl/aops_pkg.sv */
// Constants, types and state layout for the audio output power sequencer.
// Assumes a single core clock standing in for the internal master clock.
package aops_pkg;

  localparam logic [23:0] ADR_POP_A = 24'h010010;
  localparam logic [23:0] ADR_PDN   = 24'h020000;
  localparam logic [23:0] ADR_XTAL  = 24'h020052;
  localparam logic [23:0] ADR_POP_B = 24'h080032;
  localparam logic [23:0] ADR_ISTAT = 24'h0F0000;
  localparam logic [23:0] ADR_IMASK = 24'h0F0010;

  localparam int AUX_PORT_SHUTDOWN           = 7;
  localparam int MAIN_PORT_SHUTDOWN          = 6;
  localparam int BITSTREAM_INPUT_SHUTDOWN    = 5;
  localparam int OUTPUT_AMP_SHUTDOWN         = 4;
  localparam int CRYSTAL_OSCILLATOR_SHUTDOWN = 3;
  localparam int SYNTH_LOOP_SHUTDOWN         = 2;
  localparam int CLOCK_OUTPUT_SHUTDOWN       = 1;
  localparam int SHUTDOWN_COMPLETE_BIT       = 0;

  localparam logic [7:0] RST_PDN  = 8'hFE;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;

  localparam int CORE_CLK_MHZ   = 20;
  localparam int SETTLE_TIME_US = 1000;
  localparam int SETTLE_CYC_DEF = SETTLE_TIME_US * CORE_CLK_MHZ;
  localparam int AMP_OFF_CYC    = 16;
  localparam int CNT_W          = 24;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_RECV, BUS_ACK, BUS_SEND, BUS_HACK
  } aops_bus_type;

  typedef enum logic [1:0] {AMP_ON, AMP_RAMP, AMP_OFF} aops_amp_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } aops_pins_type;

  typedef struct packed {
    logic [1:0]       sclSync;
    logic [1:0]       sdaSync;
    logic             sclPrev;
    logic             sdaPrev;
    aops_bus_type     bus;
    logic [3:0]       bitCnt;
    logic [7:0]       shift;
    logic [2:0]       byteIdx;
    logic             rdMode;
    logic             incr;
    logic [23:0]      map;
    logic             sdaOe;
    logic [7:0]       popA;
    logic [7:0]       pdn;
    logic [7:0]       xtal;
    logic [7:0]       popB;
    logic [7:0]       mask;
    logic             doneFlag;
    aops_amp_type     amp;
    logic             ampOn;
    logic [CNT_W-1:0] ampCnt;
    logic [CNT_W-1:0] settleCnt;
    logic             synthSel;
    logic             clock_output_pin;
    logic             irq;
  } aops_state_type;

endpackage : aops_pkg

/* File: rtl/aops_sequencer.sv */
// Control-port slave, power-down register set and output amp sequencer.
// Assumes SCL/SDA arrive asynchronously and core_clk is the master clock.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Power-down register bit order seven to zero
// - Amp shutdown then raise completion flag
// - Mask bit zero gates completion interrupt
// - Coefficient writes while amp shutdown bit set, ramp included
// - Clock output runs at half master
// - Data path on master clock source
// - Ring oscillator until synth loop settles
// - Completion flag sticky, cleared on read
// - Interrupt holds until flag read or mask bit zero set
module aops_sequencer
  import aops_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR   = 7'h4A,
  parameter int         SETTLE_CYC = SETTLE_CYC_DEF
) (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire aops_pins_type pinIn,
  output logic               sdaOut,
  output logic               sdaOe,
  output logic [7:0]         shutdownCtrl,
  output logic [7:0]         xtalBias,
  output logic [7:0]         popFreeA,
  output logic [7:0]         popFreeB,
  output logic               ampEnable,
  output logic               coefWriteOk,
  output logic               mclkFromSynth,
  output logic               clockOutPin,
  output logic               irqOut
);
  aops_state_type s_r;
  aops_state_type s_nxt;
  logic           rise;
  logic           fall;
  logic           startCond;
  logic           stopCond;
  logic           loadTx;
  logic           statRead;
  logic           wrPdn;
  logic           doneEv;
  logic [7:0]     rdData;
  function automatic logic [7:0] regRead(input aops_state_type st);
    case (st.map)
      ADR_POP_A: regRead = st.popA;
      ADR_PDN:   regRead = st.pdn;
      ADR_XTAL:  regRead = st.xtal;
      ADR_POP_B: regRead = st.popB;
      ADR_ISTAT: regRead = {7'h00, st.doneFlag};
      ADR_IMASK: regRead = st.mask;
      default:   regRead = 8'h00;
    endcase
  endfunction : regRead
  always_comb begin
    s_nxt     = s_r;
    loadTx    = 1'b0;
    statRead  = 1'b0;
    wrPdn     = 1'b0;
    doneEv    = 1'b0;
    rdData    = regRead(s_r);
    // First stage feeds only the second stage
    s_nxt.sclSync = {s_r.sclSync[0], pinIn.scl};
    s_nxt.sdaSync = {s_r.sdaSync[0], pinIn.sda};
    s_nxt.sclPrev = s_r.sclSync[1];
    s_nxt.sdaPrev = s_r.sdaSync[1];
    rise      = s_r.sclSync[1] & ~s_r.sclPrev;
    fall      = ~s_r.sclSync[1] & s_r.sclPrev;
    startCond = s_r.sclSync[1] & s_r.sclPrev & s_r.sdaPrev
                & ~s_r.sdaSync[1];
    stopCond  = s_r.sclSync[1] & s_r.sclPrev & ~s_r.sdaPrev
                & s_r.sdaSync[1];

    case (s_r.bus)
      BUS_RECV: begin
        if (rise) begin
          s_nxt.shift  = {s_r.shift[6:0], s_r.sdaSync[1]};
          s_nxt.bitCnt = s_r.bitCnt + 4'h1;
        end else if (fall && s_r.bitCnt == 4'h8) begin
          s_nxt.bitCnt = 4'h0;
          s_nxt.bus    = BUS_ACK;
          s_nxt.sdaOe  = 1'b1;
          if (s_r.byteIdx != 3'h5) begin
            s_nxt.byteIdx = s_r.byteIdx + 3'h1;
          end
          case (s_r.byteIdx)
            3'h0: begin
              if (s_r.shift[7:1] != DEV_ADDR) begin
                s_nxt.bus   = BUS_IDLE;
                s_nxt.sdaOe = 1'b0;
              end
              s_nxt.rdMode = s_r.shift[0];
            end
            3'h1: s_nxt.map[23:16] = s_r.shift;
            3'h2: s_nxt.map[15:8]  = s_r.shift;
            3'h3: s_nxt.map[7:0]   = s_r.shift;
            3'h4: s_nxt.incr       = s_r.shift[0];
            default: begin
              case (s_r.map)
                ADR_POP_A: s_nxt.popA = s_r.shift;
                ADR_PDN: begin
                  s_nxt.pdn = {s_r.shift[7:1], 1'b0};
                  wrPdn     = 1'b1;
                end
                ADR_XTAL:  s_nxt.xtal = s_r.shift;
                ADR_POP_B: s_nxt.popB = s_r.shift;
                ADR_IMASK: s_nxt.mask = s_r.shift;
                default: ;
              endcase
              if (s_r.incr) begin
                s_nxt.map = s_r.map + 24'h1;
              end
            end
          endcase
        end
      end
      BUS_ACK: begin
        if (fall) begin
          s_nxt.sdaOe = 1'b0;
          s_nxt.bus   = BUS_RECV;
          loadTx      = s_r.rdMode;
        end
      end
      BUS_SEND: begin
        if (fall) begin
          if (s_r.bitCnt == 4'h8) begin
            s_nxt.sdaOe = 1'b0;
            s_nxt.bus   = BUS_HACK;
          end else begin
            s_nxt.shift  = {s_r.shift[6:0], 1'b0};
            s_nxt.sdaOe  = ~s_r.shift[6];
            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
          end
        end
      end
      BUS_HACK: begin
        if (rise && s_r.sdaSync[1]) begin
          s_nxt.bus = BUS_IDLE;
        end else if (fall) begin
          loadTx = 1'b1;
        end
      end
      default: ;
    endcase
    if (loadTx) begin
      s_nxt.shift  = rdData;
      s_nxt.sdaOe  = ~rdData[7];
      s_nxt.bitCnt = 4'h1;
      s_nxt.bus    = BUS_SEND;
      statRead     = (s_r.map == ADR_ISTAT);
      if (s_r.incr) begin
        s_nxt.map = s_r.map + 24'h1;
      end
    end
    if (startCond) begin
      s_nxt.bus     = BUS_RECV;
      s_nxt.bitCnt  = 4'h0;
      s_nxt.byteIdx = 3'h0;
      s_nxt.sdaOe   = 1'b0;
    end else if (stopCond) begin
      s_nxt.bus   = BUS_IDLE;
      s_nxt.sdaOe = 1'b0;
    end
    case (s_r.amp)
      AMP_ON: begin
        if (s_r.pdn[OUTPUT_AMP_SHUTDOWN]) begin
          s_nxt.amp    = AMP_RAMP;
          s_nxt.ampCnt = CNT_W'(AMP_OFF_CYC - 1);
        end
      end
      AMP_RAMP: begin
        if (!s_r.pdn[OUTPUT_AMP_SHUTDOWN]) begin
          s_nxt.amp = AMP_ON;
        end else if (s_r.ampCnt == '0) begin
          s_nxt.amp = AMP_OFF;
          doneEv    = 1'b1;
        end else begin
          s_nxt.ampCnt = s_r.ampCnt - CNT_W'(1);
        end
      end
      AMP_OFF: begin
        if (!s_r.pdn[OUTPUT_AMP_SHUTDOWN]) begin
          s_nxt.amp = AMP_ON;
        end
      end
      default: s_nxt.amp = AMP_OFF;
    endcase
    s_nxt.ampOn = (s_nxt.amp == AMP_ON);
    s_nxt.doneFlag = doneEv | (s_r.doneFlag & ~statRead);
    s_nxt.irq = s_nxt.doneFlag & ~s_nxt.mask[SHUTDOWN_COMPLETE_BIT];
    if (s_r.pdn[SYNTH_LOOP_SHUTDOWN]) begin
      s_nxt.settleCnt = '0;
      s_nxt.synthSel  = 1'b0;
    end else if (s_r.settleCnt == CNT_W'(SETTLE_CYC - 1)) begin
      s_nxt.synthSel = 1'b1;
    end else begin
      s_nxt.settleCnt = s_r.settleCnt + CNT_W'(1);
    end
    s_nxt.clock_output_pin = s_r.pdn[CLOCK_OUTPUT_SHUTDOWN] ? 1'b0 : ~s_r.clock_output_pin;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_r       <= '0;
      s_r.bus   <= BUS_IDLE;
      s_r.pdn   <= RST_PDN;
      s_r.mask  <= RST_MASK;
      s_r.popA  <= RST_ZERO;
      s_r.popB  <= RST_ZERO;
      s_r.xtal  <= RST_ZERO;
      s_r.amp   <= AMP_OFF;
      // Pins idle high, so no false edge after reset
      s_r.sclSync <= 2'h3;
      s_r.sdaSync <= 2'h3;
      s_r.sclPrev <= 1'b1;
      s_r.sdaPrev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  // Open-drain: data line only ever pulled low
  assign sdaOut        = 1'b0;
  assign sdaOe         = s_r.sdaOe;
  assign shutdownCtrl  = s_r.pdn;
  assign xtalBias      = s_r.xtal;
  assign popFreeA      = s_r.popA;
  assign popFreeB      = s_r.popB;
  assign ampEnable     = s_r.ampOn;
  // Coefficient port open whenever amp shutdown bit set, ramp included
  assign coefWriteOk   = s_r.pdn[OUTPUT_AMP_SHUTDOWN];
  assign mclkFromSynth = s_r.synthSel;
  assign clockOutPin   = s_r.clock_output_pin;
  assign irqOut        = s_r.irq;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_pdn_write;
    wrPdn |=> s_r.pdn == {$past(s_r.shift[7:1]), 1'b0};
  endproperty
  a_pdn_write: assert property (p_pdn_write) else $error("pdn write lost");
  property p_done_after_ramp;
    s_r.amp == AMP_RAMP && s_r.ampCnt == '0 && s_r.pdn[4] |=> s_r.doneFlag;
  endproperty
  a_done_after_ramp: assert property (p_done_after_ramp) else $error("no done");
  property p_irq_unmasked;
    $rose(s_r.doneFlag) && !s_r.mask[0] |-> s_r.irq;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked) else $error("irq missing");
  property p_coef_amp_off;
    s_r.amp == AMP_OFF |-> !ampEnable && $past(coefWriteOk);
  endproperty
  a_coef_amp_off: assert property (p_coef_amp_off) else $error("coef open");
  property p_clock_output_pin_toggle;
    !s_r.pdn[1] ##1 !s_r.pdn[1] |-> clockOutPin != $past(clockOutPin);
  endproperty
  a_clock_output_pin_toggle: assert property (p_clock_output_pin_toggle) else $error("clk stuck");
  property p_synth_off;
    s_r.pdn[2] |=> !mclkFromSynth;
  endproperty
  a_synth_off: assert property (p_synth_off) else $error("synth used");
  property p_settle_time;
    $rose(s_r.synthSel) |-> $past(s_r.settleCnt) == CNT_W'(SETTLE_CYC - 1);
  endproperty
  a_settle_time: assert property (p_settle_time) else $error("early switch");
  property p_sticky;
    s_r.doneFlag && !statRead |=> s_r.doneFlag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_irq_hold;
    s_r.irq && !statRead && !s_nxt.mask[0] |=> s_r.irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_no_spurious;
    $rose(s_r.doneFlag) |-> $past(s_r.amp) == AMP_RAMP && $past(s_r.pdn[4]);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("bad done");
  c_done: cover property ($rose(s_r.doneFlag));
  c_stat_read: cover property (statRead && s_r.doneFlag);
  c_synth: cover property ($rose(s_r.synthSel));
  c_irq: cover property ($rose(s_r.irq));
endmodule : aops_sequencer
`default_nettype wire

/* File: tb/aops_host_model.sv */
// Host side model: bit-level control-port master and register tasks.
// Assumes a pulled-up SDA wire and eight core_clk cycles per SCL period.
`timescale 1ns/1ps
`default_nettype none
module aops_host_model #(
  parameter logic [7:0] ADDR_W = 8'h94
) (
  input  wire logic core_clk,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaLow
);
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // SDA moves mid-low only, so no false start or stop
  task automatic bitx(input logic b, output logic s);
    tick(2);
    sdaLow <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    s = sdaWire;
    tick(1);
    scl <= 1'b0;
  endtask : bitx
  task automatic start();
    tick(1);
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    tick(2);
    sdaLow <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b0;
    tick(8);
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], s);
      q[i] = s;
    end
    bitx(a, k);
  endtask : xfer
  task automatic hdr(input logic [23:0] a, output logic ok);
    logic [39:0] s;
    logic [7:0]  q;
    logic        k;
    s  = {ADDR_W, a, 8'h00};
    ok = 1'b1;
    start();
    for (int i = 0; i < 5; i++) begin
      xfer(s[39-8*i -: 8], 1'b1, q, k);
      ok = ok & ~k;
    end
  endtask : hdr
  task automatic wr(input logic [23:0] a, input logic [7:0] v,
                    output logic ok);
    logic [7:0] q;
    logic       k;
    hdr(a, ok);
    xfer(v, 1'b1, q, k);
    ok = ok & ~k;
    stop();
  endtask : wr
  task automatic rd(input logic [23:0] a, output logic [7:0] v,
                    output logic ok);
    logic [7:0] q;
    logic       k;
    hdr(a, ok);
    stop();
    start();
    xfer(ADDR_W | 8'h01, 1'b1, q, k);
    ok = ok & ~k;
    // Single byte read, so the host answers with a NACK
    xfer(8'hFF, 1'b1, v, k);
    stop();
  endtask : rd
  task automatic rmw(input logic [23:0] a, input logic [7:0] am,
                     input logic [7:0] om);
    logic [7:0] v;
    logic       ok;
    rd(a, v, ok);
    wr(a, (v & am) | om, ok);
  endtask : rmw
endmodule : aops_host_model
`default_nettype wire

/* File: tb/test_audio_output_power_sequencer.sv */
// Bench for the power sequencer: register sequences over the control port.
// Assumes the host model and the sequencer share the 20 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module test_audio_output_power_sequencer
  import aops_pkg::*;
;
  localparam int LIMIT = 60000;
  logic          core_clk, reset, scl, hostLow, ok;
  logic          sdaOut, sdaOe, ampEnable, coefWriteOk;
  logic          mclkFromSynth, clockOutPin, irqOut;
  logic [7:0]    shutdownCtrl, xtalBias, popFreeA, popFreeB, v;
  logic [7:0]    ifc [3] = '{8'h7F, 8'hBF, 8'hDF};
  wire logic     sdaWire;
  aops_pins_type pins;
  int            errCount = 0;
  int            nChecks = 0;
  int            cyc = 0;
  // Open drain wire with pull-up
  assign sdaWire = ~(hostLow | (sdaOe & ~sdaOut));
  assign pins = {scl, sdaWire};
  aops_sequencer #(.SETTLE_CYC(20)) u_dut (
    .core_clk(core_clk), .reset(reset), .pinIn(pins),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .shutdownCtrl(shutdownCtrl),
    .xtalBias(xtalBias), .popFreeA(popFreeA), .popFreeB(popFreeB),
    .ampEnable(ampEnable), .coefWriteOk(coefWriteOk),
    .mclkFromSynth(mclkFromSynth), .clockOutPin(clockOutPin),
    .irqOut(irqOut)
  );
  aops_host_model u_h (
    .core_clk(core_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(hostLow)
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    nChecks++;
    if (s !== e) begin
      errCount++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(input logic [23:0] a, input logic [7:0] e);
    u_h.rd(a, v, ok);
    chk("readback", v, e);
  endtask : rdc
  // Bounded wait for the completion interrupt
  task automatic wt();
    for (int i = 0; i < 40 && irqOut !== 1'b1; i++) @(posedge core_clk);
  endtask : wt
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errCount++;
      end_sim();
    end
  end
  initial begin
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("pdn", shutdownCtrl, 8'hFE);
    chk("coefOk", coefWriteOk, 1'b1);
    chk("synth", mclkFromSynth, 1'b0);
    chk("clock_output_pin", clockOutPin, 1'b0);
    rdc(ADR_PDN, 8'hFE);
    u_h.rmw(ADR_PDN, 8'hF9, 8'h00);
    repeat (20) @(posedge core_clk);
    chk("synth", mclkFromSynth, 1'b1);
    for (int i = 0; i < 4; i++) begin
      v[0] = clockOutPin;
      @(posedge core_clk);
      chk("clock_output_pin", clockOutPin, {7'h00, ~v[0]});
    end
    u_h.wr(ADR_XTAL, 8'h04, ok);
    chk("xtal", xtalBias, 8'h04);
    u_h.wr(ADR_POP_A, 8'h99, ok);
    u_h.wr(ADR_POP_B, 8'h20, ok);
    chk("popA", popFreeA, 8'h99);
    chk("popB", popFreeB, 8'h20);
    u_h.rmw(ADR_PDN, 8'hBF, 8'h00);
    u_h.rmw(ADR_PDN, 8'hEF, 8'h00);
    chk("pdn", shutdownCtrl, 8'hA8);
    chk("amp", ampEnable, 1'b1);
    chk("coefOk", coefWriteOk, 1'b0);
    u_h.wr(ADR_POP_B, 8'h00, ok);
    u_h.wr(ADR_POP_A, 8'h00, ok);
    chk("popA", popFreeA, 8'h00);
    u_h.rmw(ADR_IMASK, 8'hFE, 8'h00);
    rdc(ADR_IMASK, 8'hFE);
    rdc(ADR_ISTAT, 8'h00);
    u_h.rmw(ADR_PDN, 8'hFF, 8'h10);
    chk("amp", ampEnable, 1'b0);
    wt();
    chk("irq", irqOut, 1'b1);
    rdc(ADR_ISTAT, 8'h01);
    chk("irq", irqOut, 1'b0);
    rdc(ADR_ISTAT, 8'h00);
    u_h.rmw(ADR_PDN, 8'hFF, 8'h40);
    chk("pdn", shutdownCtrl, 8'hF8);
    u_h.wr(ADR_PDN, 8'hF8, ok);
    rdc(ADR_ISTAT, 8'h00);
    foreach (ifc[i]) begin
      u_h.rmw(ADR_PDN, ifc[i], 8'h00);
      chk("pdn", shutdownCtrl, 8'hF8 & ifc[i]);
      u_h.rmw(ADR_PDN, 8'hEF, 8'h00);
      chk("amp", ampEnable, 1'b1);
      u_h.rmw(ADR_PDN, 8'hFF, 8'h10);
      wt();
      rdc(ADR_ISTAT, 8'h01);
      u_h.rmw(ADR_PDN, 8'hFF, 8'hE0);
      chk("pdn", shutdownCtrl, 8'hF8);
    end
    u_h.wr(ADR_IMASK, 8'hFF, ok);
    u_h.rmw(ADR_PDN, 8'hEF, 8'h00);
    u_h.rmw(ADR_PDN, 8'hFF, 8'h10);
    repeat (40) @(posedge core_clk);
    chk("irq", irqOut, 1'b0);
    rdc(ADR_ISTAT, 8'h01);
    end_sim();
  end
endmodule : test_audio_output_power_sequencer
`default_nettype wire
